/* File: rtl/vpe_element.sv */
// Voltage protection element with APB register access
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ns

module vpe_element #(
    parameter int TICK_CYCLES = vpe_pkg::TICK_CYCLES   // Cycles per millisecond
) (
    input  wire logic              REF_CLK,                 // 20 MHz clock
    input  wire logic              RST_N,                   // Synchronous reset, low
    input  wire logic              PSEL,                    // APB select
    input  wire logic              PENABLE,                 // APB enable
    input  wire logic              PWRITE,                  // APB write
    input  wire logic [7:0]        PADDR,                   // APB address
    input  wire logic [31:0]       PWDATA,                  // APB write data
    output logic                   PREADY,                  // APB ready
    output logic      [31:0]       PRDATA,                  // APB read data
    output logic                   PSLVERR,                 // APB error
    input  wire vpe_pkg::vpe_tri_t V_FUND,                  // Fundamental magnitudes
    input  wire vpe_pkg::vpe_tri_t V_RMS,                   // True RMS magnitudes
    input  wire vpe_pkg::vpe_tri_t V_AVG,                   // Sliding average magnitudes
    input  wire vpe_pkg::vpe_tri_t I_PHASE,                 // Phase current magnitudes
    input  wire logic              EXTERNAL_BLOCK_INPUT,    // External block pin
    output logic      [2:0]        PHASE_PICKUP_FLAG,       // Per-phase alarm
    output logic      [2:0]        PHASE_TRIP_FLAG,         // Per-phase trip
    output logic                   PICKUP,                  // Element alarm
    output logic                   TRIP,                    // Element trip
    output logic                   BLOCKED                  // Element blocked
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        vpe_pkg::vpe_ctrl_t    ctrl;
        logic [15:0]           rating;
        logic [15:0]           thresh;
        logic [7:0]            dropout;
        logic [15:0]           tdelay;
        logic [15:0]           imin;
        logic [15:0]           imin_delay;
        logic                  pready;
        logic [31:0]           prdata;
        logic                  pslverr;
        logic                  ext_s1;
        logic                  ext_s2;
        vpe_pkg::vpe_imstate_t im_state;
        logic [14:0]           im_sub;
        logic [15:0]           im_cnt;
        logic [14:0]           tr_sub;
        logic [15:0]           tr_cnt;
        logic [2:0]            pk;
        logic [2:0]            pk_flag;
        logic [2:0]            trip_flag;
        logic                  pickup;
        logic                  trip;
        logic                  blocked;
    } vpe_state_t;

    localparam vpe_state_t STATE_RST = '{
        ctrl:       vpe_pkg::RST_CTRL,
        rating:     vpe_pkg::RST_RATING,
        thresh:     vpe_pkg::RST_THRESH,
        dropout:    vpe_pkg::RST_DROPOUT,
        tdelay:     vpe_pkg::RST_TDELAY,
        imin:       vpe_pkg::RST_IMIN,
        imin_delay: vpe_pkg::RST_IMIN_DELAY,
        im_state:   vpe_pkg::IM_LIVE,
        default:    '0
    };

    localparam logic [14:0] TICK_LAST = 15'(TICK_CYCLES - 1);

    vpe_state_t st_ff;
    vpe_state_t nxt_st;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] sel_meas(input logic [1:0] meth,
                                             input logic [15:0] f,
                                             input logic [15:0] r,
                                             input logic [15:0] a);
        logic [15:0] v;
        case (meth)
            vpe_pkg::METH_RMS: v = r;
            vpe_pkg::METH_AVG: v = a;  // Averaged upstream over the set window
            default:           v = f;
        endcase
        return v;
    endfunction : sel_meas

    function automatic logic is_mapped(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= vpe_pkg::ADDR_STATUS);
    endfunction : is_mapped

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic [15:0] vn;
    logic [31:0] vn_scaled;
    logic [39:0] lvl;
    logic [39:0] lvl_pct;
    logic [39:0] vs;
    logic [39:0] vs_pct;
    logic [15:0] v;
    logic        meas_pp;
    logic        all_dead;
    logic        im_block;
    logic        blk;
    logic [1:0]  n_pk;
    logic [1:0]  need;
    logic        pick;
    logic        wr;

    always_comb begin
        nxt_st    = st_ff;
        vn        = '0;
        vn_scaled = '0;
        lvl       = '0;
        lvl_pct   = '0;
        vs        = '0;
        vs_pct    = '0;
        v         = '0;
        all_dead  = 1'b1;
        n_pk      = '0;

        // ------------------------------------------------------------------
        // APB slave
        // ------------------------------------------------------------------
        nxt_st.pready  = PSEL & ~PENABLE;
        nxt_st.pslverr = PSEL & ~PENABLE & ~is_mapped(PADDR);
        if (PSEL && !PENABLE) begin
            case (PADDR)
                vpe_pkg::ADDR_CTRL:       nxt_st.prdata = st_ff.ctrl;
                vpe_pkg::ADDR_RATING:     nxt_st.prdata = {16'h0000, st_ff.rating};
                vpe_pkg::ADDR_THRESH:     nxt_st.prdata = {16'h0000, st_ff.thresh};
                vpe_pkg::ADDR_DROPOUT:    nxt_st.prdata = {24'h00_0000, st_ff.dropout};
                vpe_pkg::ADDR_TDELAY:     nxt_st.prdata = {16'h0000, st_ff.tdelay};
                vpe_pkg::ADDR_IMIN:       nxt_st.prdata = {16'h0000, st_ff.imin};
                vpe_pkg::ADDR_IMIN_DELAY: nxt_st.prdata = {16'h0000, st_ff.imin_delay};
                vpe_pkg::ADDR_STATUS:     nxt_st.prdata = {20'h0_0000, st_ff.im_state,
                                                           st_ff.ext_s2, st_ff.blocked,
                                                           st_ff.trip, st_ff.pickup,
                                                           st_ff.trip_flag, st_ff.pk_flag};
                default:                  nxt_st.prdata = 32'h0000_0000;
            endcase
        end
        wr = PSEL & PENABLE & st_ff.pready & PWRITE;
        if (wr) begin
            case (PADDR)
                vpe_pkg::ADDR_CTRL:       nxt_st.ctrl = {22'h00_0000, PWDATA[9:0]};
                vpe_pkg::ADDR_RATING:     nxt_st.rating = PWDATA[15:0];
                vpe_pkg::ADDR_THRESH:     nxt_st.thresh = PWDATA[15:0];
                vpe_pkg::ADDR_DROPOUT:    nxt_st.dropout = PWDATA[7:0];
                vpe_pkg::ADDR_TDELAY:     nxt_st.tdelay = PWDATA[15:0];
                vpe_pkg::ADDR_IMIN:       nxt_st.imin = PWDATA[15:0];
                vpe_pkg::ADDR_IMIN_DELAY: nxt_st.imin_delay = PWDATA[15:0];
                default:                  nxt_st.ctrl = st_ff.ctrl;  // Status and holes ignored
            endcase
        end

        // ------------------------------------------------------------------
        // External block synchroniser
        // ------------------------------------------------------------------
        nxt_st.ext_s1 = EXTERNAL_BLOCK_INPUT;
        nxt_st.ext_s2 = st_ff.ext_s1;

        // ------------------------------------------------------------------
        // Minimum current check
        // ------------------------------------------------------------------
        for (int i = 0; i < 3; i++) begin
            if (I_PHASE[i] >= st_ff.imin) begin
                all_dead = 1'b0;
            end
        end
        nxt_st.im_sub = (st_ff.im_sub == TICK_LAST) ? 15'h0000 : st_ff.im_sub + 15'h0001;
        if (!(st_ff.ctrl.under && st_ff.ctrl.imin_en)) begin
            nxt_st.im_state = vpe_pkg::IM_LIVE;
        end else begin
            case (st_ff.im_state)
                vpe_pkg::IM_LIVE: begin
                    if (all_dead) begin
                        nxt_st.im_state = vpe_pkg::IM_DEAD;
                    end
                end
                vpe_pkg::IM_DEAD: begin
                    if (!all_dead) begin
                        nxt_st.im_state = vpe_pkg::IM_REARM;
                        nxt_st.im_cnt   = 16'h0000;
                        nxt_st.im_sub   = 15'h0000;
                    end
                end
                vpe_pkg::IM_REARM: begin
                    if (all_dead) begin
                        nxt_st.im_state = vpe_pkg::IM_DEAD;
                    end else if (st_ff.im_cnt >= st_ff.imin_delay) begin
                        nxt_st.im_state = vpe_pkg::IM_LIVE;
                    end else if (st_ff.im_sub == TICK_LAST) begin
                        nxt_st.im_cnt = st_ff.im_cnt + 16'h0001;
                    end
                end
                default: nxt_st.im_state = vpe_pkg::IM_LIVE;
            endcase
        end
        // Block in the same cycle the currents die, not one later
        im_block = st_ff.ctrl.under & st_ff.ctrl.imin_en &
                   ((st_ff.im_state != vpe_pkg::IM_LIVE) | all_dead);
        blk = ~st_ff.ctrl.enable | im_block |
              (st_ff.ctrl.ext_blk_en & st_ff.ext_s2);

        // ------------------------------------------------------------------
        // Levels
        // ------------------------------------------------------------------
        meas_pp   = st_ff.ctrl.conn_pp | st_ff.ctrl.meas_pp;
        vn_scaled = st_ff.rating * vpe_pkg::INV_SQRT3_Q16;
        vn        = meas_pp ? st_ff.rating : vn_scaled[31:16];
        lvl       = {8'h00, 32'(vn) * 32'(st_ff.thresh)};
        lvl_pct   = 40'(lvl * {32'h0000_0000, st_ff.dropout});

        // ------------------------------------------------------------------
        // Per-phase pickup with hysteresis
        // ------------------------------------------------------------------
        for (int i = 0; i < 3; i++) begin
            // Channel i is phase i or line pair i, per connection
            v      = sel_meas(st_ff.ctrl.method, V_FUND[i], V_RMS[i], V_AVG[i]);
            vs     = {14'h0000, v, 10'h000};
            vs_pct = 40'(vs * vpe_pkg::PCT_SCALE);
            if (blk) begin
                nxt_st.pk[i] = 1'b0;
            end else if (!st_ff.pk[i]) begin
                nxt_st.pk[i] = st_ff.ctrl.under ? (vs <= lvl) : (vs >= lvl);
            end else if (st_ff.ctrl.under) begin
                nxt_st.pk[i] = ~(vs_pct >= lvl_pct);
            end else begin
                nxt_st.pk[i] = ~(vs_pct <= lvl_pct);
            end
            n_pk = n_pk + {1'b0, nxt_st.pk[i]};
        end
        need = (st_ff.ctrl.need == 2'h0) ? 2'h1 : st_ff.ctrl.need;
        pick = ~blk & (n_pk >= need);

        // ------------------------------------------------------------------
        // Trip delay
        // ------------------------------------------------------------------
        if (!pick) begin
            nxt_st.tr_cnt = 16'h0000;
            nxt_st.tr_sub = 15'h0000;
            nxt_st.trip   = 1'b0;
        end else if (st_ff.pickup && st_ff.tr_cnt >= st_ff.tdelay) begin
            nxt_st.trip = 1'b1;
        end else if (st_ff.pickup) begin
            nxt_st.tr_sub = (st_ff.tr_sub == TICK_LAST) ? 15'h0000 : st_ff.tr_sub + 15'h0001;
            if (st_ff.tr_sub == TICK_LAST) begin
                nxt_st.tr_cnt = st_ff.tr_cnt + 16'h0001;
            end
        end
        nxt_st.pickup    = pick;
        nxt_st.pk_flag   = nxt_st.pk & {3{pick}};
        nxt_st.trip_flag = nxt_st.pk & {3{nxt_st.trip}};
        nxt_st.blocked   = blk;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            st_ff <= STATE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign PREADY            = st_ff.pready;
    assign PRDATA            = st_ff.prdata;
    assign PSLVERR           = st_ff.pslverr;
    assign PHASE_PICKUP_FLAG = st_ff.pk_flag;
    assign PHASE_TRIP_FLAG   = st_ff.trip_flag;
    assign PICKUP            = st_ff.pickup;
    assign TRIP              = st_ff.trip;
    assign BLOCKED           = st_ff.blocked;

endmodule : vpe_element

/* File: rtl/vpe_pkg.sv */
// Package of constants and types for the voltage protection element
package vpe_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses on APB)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_RATING     = 8'h04;
    localparam logic [7:0] ADDR_THRESH     = 8'h08;
    localparam logic [7:0] ADDR_DROPOUT    = 8'h0C;
    localparam logic [7:0] ADDR_TDELAY     = 8'h10;
    localparam logic [7:0] ADDR_IMIN       = 8'h14;
    localparam logic [7:0] ADDR_IMIN_DELAY = 8'h18;
    localparam logic [7:0] ADDR_STATUS     = 8'h1C;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_RATING     = 16'h2710;
    localparam logic [15:0] RST_THRESH     = 16'h0400;
    localparam logic [7:0]  RST_DROPOUT    = 8'h61;
    localparam logic [15:0] RST_TDELAY     = 16'h0064;
    localparam logic [15:0] RST_IMIN       = 16'h0000;
    localparam logic [15:0] RST_IMIN_DELAY = 16'h0064;

    // ------------------------------------------------------------------
    // Scaling and timing
    // ------------------------------------------------------------------
    localparam logic [15:0] INV_SQRT3_Q16 = 16'h93CD;
    localparam logic [39:0] PCT_SCALE     = 40'h00_0000_0064;
    localparam int          AVG_WINDOW_MIN = 10;
    localparam int          CLK_PERIOD_NS  = 50;
    localparam int          TICK_TIME_NS   = 1000000;
    localparam int          TICK_CYCLES    = TICK_TIME_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        METH_FUND = 2'h0,
        METH_RMS  = 2'h1,
        METH_AVG  = 2'h2
    } vpe_method_t;

    typedef enum logic [1:0] {
        IM_LIVE  = 2'b00,
        IM_DEAD  = 2'b01,
        IM_REARM = 2'b11
    } vpe_imstate_t;

    typedef logic [2:0][15:0] vpe_tri_t;

    typedef struct packed {
        logic [21:0] rsvd;
        logic        ext_blk_en;
        logic        imin_en;
        logic [1:0]  need;
        logic        meas_pp;
        logic        conn_pp;
        logic [1:0]  method;
        logic        under;
        logic        enable;
    } vpe_ctrl_t;

    localparam vpe_ctrl_t RST_CTRL = '0;

endpackage : vpe_pkg

/* File: testbench/vpe_element_properties.sv */
// Port-level checks for the voltage protection element
`timescale 1ns/1ns

module vpe_element_properties #(
    parameter int TICK_CYCLES = 4         // Cycles per millisecond
) (
    input wire logic        REF_CLK,           // Clock
    input wire logic        RST_N,             // Reset, low
    input wire logic        PSEL,              // APB select
    input wire logic        PENABLE,           // APB enable
    input wire logic [7:0]  PADDR,             // APB address
    input wire logic        PREADY,            // APB ready
    input wire logic [31:0] PRDATA,            // APB read data
    input wire logic        PSLVERR,           // APB error
    input wire logic [2:0]  PHASE_PICKUP_FLAG, // Per-phase alarm
    input wire logic [2:0]  PHASE_TRIP_FLAG,   // Per-phase trip
    input wire logic        PICKUP,            // Element alarm
    input wire logic        TRIP,              // Element trip
    input wire logic        BLOCKED            // Element blocked
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    // ------------------------------------------------------------------
    // Bus
    // ------------------------------------------------------------------
    ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("ready missing after setup");
    ready_single_a: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    error_decode_a: assert property (PREADY |-> PSLVERR == (PADDR > 8'h1C || PADDR[1:0] != 2'b00))
        else $error("error flag does not match address");
    error_data_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0000_0000)
        else $error("error without ready or with data");

    // ------------------------------------------------------------------
    // Protection outputs
    // ------------------------------------------------------------------
    pickup_flags_a: assert property (PICKUP == (PHASE_PICKUP_FLAG != 3'b000))
        else $error("pickup and phase flags disagree");
    trip_flags_a: assert property (PHASE_TRIP_FLAG == (TRIP ? PHASE_PICKUP_FLAG : 3'b000))
        else $error("trip flags disagree");
    trip_after_pickup_a: assert property ($rose(TRIP) |-> $past(PICKUP) && PICKUP)
        else $error("trip without earlier pickup");
    blocked_quiet_a: assert property (BLOCKED |-> !PICKUP && !TRIP)
        else $error("outputs active while blocked");

    cover property ($rose(TRIP));
    cover property ($rose(BLOCKED));
    cover property (PSLVERR);
endmodule : vpe_element_properties

bind vpe_element vpe_element_properties #(.TICK_CYCLES(TICK_CYCLES)) props_u (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
    .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .PHASE_PICKUP_FLAG(PHASE_PICKUP_FLAG), .PHASE_TRIP_FLAG(PHASE_TRIP_FLAG),
    .PICKUP(PICKUP), .TRIP(TRIP), .BLOCKED(BLOCKED));

/* File: testbench/vpe_meter_model.sv */
// Measuring transformer model: presents set values one cycle later
`timescale 1ns/1ns

module vpe_meter_model (
    input  wire logic              clk,      // Clock
    input  wire vpe_pkg::vpe_tri_t set_fund, // Wanted fundamental
    input  wire vpe_pkg::vpe_tri_t set_rms,  // Wanted true RMS
    input  wire vpe_pkg::vpe_tri_t set_avg,  // Wanted sliding average
    input  wire vpe_pkg::vpe_tri_t set_cur,  // Wanted phase currents
    output vpe_pkg::vpe_tri_t      v_fund,   // Fundamental out
    output vpe_pkg::vpe_tri_t      v_rms,    // True RMS out
    output vpe_pkg::vpe_tri_t      v_avg,    // Sliding average out
    output vpe_pkg::vpe_tri_t      i_phase   // Currents out
);
    always_ff @(posedge clk) begin
        v_fund  <= set_fund;
        v_rms   <= set_rms;
        v_avg   <= set_avg;
        i_phase <= set_cur;
    end
endmodule : vpe_meter_model

/* File: testbench/testbench.sv */
// Self-checking bench for the voltage protection element
`timescale 1ns/1ns

module testbench;
    localparam int          TICK = 4;
    localparam logic [15:0] ZERO = 16'h0000;
    localparam logic [15:0] HI   = 16'h07D0;
    localparam logic [15:0] NOM  = 16'h03E8;
    logic              ref_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0000_0000;
    logic              ext_blk = 1'b0;
    vpe_pkg::vpe_tri_t vf = '0;
    vpe_pkg::vpe_tri_t vr = '0;
    vpe_pkg::vpe_tri_t va = '0;
    vpe_pkg::vpe_tri_t ic = '0;
    vpe_pkg::vpe_tri_t mf, mr, ma, mi;
    logic              pready, pslverr, pk, tr, bl;
    logic [31:0]       prdata, q;
    logic [2:0]        pf, tf;
    logic              e;
    int                n;
    int                miscompares = 0;
    int                checked = 0;
    logic [31:0]       rv [7] = '{32'h0000_0000, 32'h0000_2710, 32'h0000_0400,
                                  32'h0000_0061, 32'h0000_0064, 32'h0000_0000, 32'h0000_0064};

    always #25 ref_clk = ~ref_clk;

    vpe_meter_model meter_u (.clk(ref_clk), .set_fund(vf), .set_rms(vr), .set_avg(va),
        .set_cur(ic), .v_fund(mf), .v_rms(mr), .v_avg(ma), .i_phase(mi));

    vpe_element #(.TICK_CYCLES(TICK)) dut_u (.REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
        .PRDATA(prdata), .PSLVERR(pslverr), .V_FUND(mf), .V_RMS(mr), .V_AVG(ma),
        .I_PHASE(mi), .EXTERNAL_BLOCK_INPUT(ext_blk), .PHASE_PICKUP_FLAG(pf),
        .PHASE_TRIP_FLAG(tf), .PICKUP(pk), .TRIP(tr), .BLOCKED(bl));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic print_verdict();
        if (miscompares == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) miscompares++;
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    // Outputs packed as blocked, trip, pickup, trip flags, pickup flags
    task automatic expect_out(input logic [8:0] x);
        repeat (4) @(posedge ref_clk);
        check({23'h0, bl, tr, pk, tf, pf}, {23'h0, x});
        apb(1'b0, vpe_pkg::ADDR_STATUS, 32'h0000_0000);
        check({23'h0, q[8:0]}, {23'h0, x});
    endtask : expect_out

    function automatic logic [31:0] mk(input logic u, input logic [1:0] m, input logic cp,
                                       input logic mp, input logic [1:0] nd, input logic ex);
        return {22'h0, ex, 1'b0, nd, mp, cp, m, u, 1'b1};
    endfunction : mk

    function automatic vpe_pkg::vpe_tri_t t3(input logic [15:0] a, b, c);
        return {c, b, a};
    endfunction : t3

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0000_0000);
            check(q, rv[i]);
        end
        expect_out(9'h100);
        apb(1'b1, 8'h22, 32'h0000_0001);
        check({31'h0, e}, 32'h0000_0001);
        apb(1'b0, 8'h20, 32'h0000_0000);
        check(q, 32'h0000_0000);
        wr(vpe_pkg::ADDR_RATING, 32'h0000_03E8);
        wr(vpe_pkg::ADDR_IMIN_DELAY, 32'h0000_0005);
        // Line voltages, threshold 1000, release at 970 or below
        wr(vpe_pkg::ADDR_CTRL, mk(1'b0, 2'h0, 1'b1, 1'b0, 2'h1, 1'b0));
        @(posedge ref_clk) vf <= t3(NOM, ZERO, ZERO);
        expect_out(9'h041);
        @(posedge ref_clk) vf <= t3(16'h03CF, ZERO, ZERO);
        expect_out(9'h041);
        @(posedge ref_clk) vf <= t3(16'h03CA, ZERO, ZERO);
        expect_out(9'h000);
        @(posedge ref_clk) vf <= t3(ZERO, ZERO, NOM);
        expect_out(9'h044);
        wr(vpe_pkg::ADDR_CTRL, mk(1'b0, 2'h0, 1'b1, 1'b0, 2'h2, 1'b0));
        expect_out(9'h000);
        @(posedge ref_clk) vf <= t3(NOM, ZERO, NOM);
        expect_out(9'h045);
        wr(vpe_pkg::ADDR_CTRL, mk(1'b0, 2'h0, 1'b1, 1'b0, 2'h3, 1'b0));
        expect_out(9'h000);
        @(posedge ref_clk) vf <= t3(NOM, NOM, NOM);
        expect_out(9'h047);
        // Measuring method selects the compared channel
        @(posedge ref_clk) vf <= t3(ZERO, ZERO, ZERO);
        vr <= t3(ZERO, NOM, ZERO);
        wr(vpe_pkg::ADDR_CTRL, mk(1'b0, 2'h1, 1'b1, 1'b0, 2'h1, 1'b0));
        expect_out(9'h042);
        wr(vpe_pkg::ADDR_CTRL, mk(1'b0, 2'h2, 1'b1, 1'b0, 2'h1, 1'b0));
        expect_out(9'h000);
        @(posedge ref_clk) va <= t3(ZERO, NOM, ZERO);
        expect_out(9'h042);
        @(posedge ref_clk) va <= t3(16'h01F4, HI, HI);
        wr(vpe_pkg::ADDR_CTRL, mk(1'b1, 2'h2, 1'b1, 1'b0, 2'h1, 1'b0));
        expect_out(9'h041);
        wr(vpe_pkg::ADDR_DROPOUT, 32'h0000_0067);
        // Undervoltage, release at 1030 or above
        @(posedge ref_clk) vf <= t3(16'h03DE, HI, HI);
        wr(vpe_pkg::ADDR_CTRL, mk(1'b1, 2'h0, 1'b1, 1'b0, 2'h1, 1'b0));
        expect_out(9'h041);
        @(posedge ref_clk) vf <= t3(16'h0405, HI, HI);
        expect_out(9'h041);
        @(posedge ref_clk) vf <= t3(16'h0406, HI, HI);
        expect_out(9'h000);
        wr(vpe_pkg::ADDR_DROPOUT, 32'h0000_0061);
        wr(vpe_pkg::ADDR_CTRL, 32'h0000_0000);
        // Phase voltages: 1000 * 0x93CD >> 16 gives threshold 577
        @(posedge ref_clk) vf <= t3(ZERO, ZERO, 16'h0240);
        wr(vpe_pkg::ADDR_CTRL, mk(1'b0, 2'h0, 1'b0, 1'b0, 2'h1, 1'b0));
        expect_out(9'h000);
        @(posedge ref_clk) vf <= t3(ZERO, ZERO, 16'h0241);
        expect_out(9'h044);
        wr(vpe_pkg::ADDR_CTRL, mk(1'b0, 2'h0, 1'b0, 1'b1, 2'h1, 1'b0));
        expect_out(9'h000);
        wr(vpe_pkg::ADDR_CTRL, mk(1'b0, 2'h0, 1'b1, 1'b0, 2'h1, 1'b0));
        expect_out(9'h000);
        @(posedge ref_clk) vf <= t3(ZERO, ZERO, NOM);
        expect_out(9'h044);
        @(posedge ref_clk) ext_blk <= 1'b1;
        wr(vpe_pkg::ADDR_CTRL, mk(1'b0, 2'h0, 1'b1, 1'b0, 2'h1, 1'b1));
        expect_out(9'h100);
        wr(vpe_pkg::ADDR_CTRL, mk(1'b0, 2'h0, 1'b1, 1'b0, 2'h1, 1'b0));
        expect_out(9'h044);
        // Minimum current 100, currents 50, re-enable after 5 ms
        @(posedge ref_clk) ext_blk <= 1'b0;
        vf <= t3(16'h01F4, 16'h01F4, 16'h01F4);
        ic <= t3(16'h0032, 16'h0032, 16'h0032);
        wr(vpe_pkg::ADDR_IMIN, 32'h0000_0064);
        wr(vpe_pkg::ADDR_CTRL, mk(1'b1, 2'h0, 1'b1, 1'b0, 2'h1, 1'b0));
        expect_out(9'h047);
        wr(vpe_pkg::ADDR_CTRL, 32'h0000_0113);
        expect_out(9'h100);
        @(posedge ref_clk) ic <= t3(16'h0032, 16'h00C8, 16'h0032);
        repeat (8) @(posedge ref_clk);
        check({31'h0, bl}, 32'h0000_0001);
        repeat (24) @(posedge ref_clk);
        expect_out(9'h047);
        // Trip 10 ms after pickup, timer restarted by a dropout
        wr(vpe_pkg::ADDR_TDELAY, 32'h0000_000A);
        @(posedge ref_clk) vf <= t3(ZERO, ZERO, ZERO);
        wr(vpe_pkg::ADDR_CTRL, mk(1'b0, 2'h0, 1'b1, 1'b0, 2'h1, 1'b0));
        @(posedge ref_clk) vf <= t3(NOM, ZERO, ZERO);
        repeat (20) @(posedge ref_clk);
        vf <= t3(ZERO, ZERO, ZERO);
        repeat (4) @(posedge ref_clk);
        vf <= t3(NOM, ZERO, ZERO);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (tr !== 1'b1 && n < 100);
        check(32'(n >= 40 && n <= 50), 32'h0000_0001);
        expect_out(9'h0C9);
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        print_verdict();
    end
endmodule : testbench
